// *** logic/dss_select.sv ***
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Terminal coded 22 acts as source selector
// - Selector off: first command and frequency sources
// - Selector on: second command and frequency sources
// - Both sources switch together, same cycle
// - Code 0 keypad keys, code 3 serial
// - Code 1: forward input forward, reverse reverse
// - Code 2: forward run/stop, reverse sets direction
// - Frequency codes 0,1 pick keypad settings
// - Codes 2-5 pot, voltage, current, shared voltage
// - Codes 6-8 combine pot with another input
// - Serial and shared-input codes need advanced variant
// - Terminals four and five only on advanced
// - Code 2 keeps running while forward on
// - Back to serial source stops if commanded
// - Forward off at switch means stop
module dss_select
  import dss_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic [31:0]                rdata,
  input  wire logic [4:0]            term_in,
  input  wire logic                  forward_run_input,
  input  wire logic                  reverse_input,
  input  wire logic                  key_run,
  input  wire logic                  key_stop,
  input  wire logic                  advanced_io,
  input  wire logic                  serial_run,
  input  wire logic                  serial_reverse,
  output dss_run_t                   run_cmd,
  output logic                       stop_request,
  output logic                       second_active,
  output dss_frq_route_t             frq_route,
  output logic                       cfg_invalid
);

  // Pin synchronisers; first stage feeds only the second
  // The variant strap goes through them too, it is a pin like the rest
  logic [9:0] pin_meta_q;
  logic [9:0] pin_sync_q;
  logic       key_run_prev_q;
  always_ff @(posedge clk) begin
    pin_meta_q <= {advanced_io, key_stop, key_run, reverse_input, forward_run_input, term_in};
    pin_sync_q <= pin_meta_q;
  end

  wire logic [4:0] term_s  = pin_sync_q[4:0];
  wire logic       fwd_s   = pin_sync_q[5];
  wire logic       rev_s   = pin_sync_q[6];
  wire logic       krun_s  = pin_sync_q[7];
  wire logic       kstop_s = pin_sync_q[8];
  wire logic       adv_s   = pin_sync_q[9];

  // Settings registers
  dss_cmd_t   cmd1_q, cmd2_q;
  logic [3:0] frq1_q, frq2_q;
  logic [4:0] tfn_q [DSS_NUM_TERM];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_cmd1 = wr_stb && hit(addr, DSS_OFS_CMD1);
  wire logic wr_frq1 = wr_stb && hit(addr, DSS_OFS_FRQ1);
  wire logic wr_cmd2 = wr_stb && hit(addr, DSS_OFS_CMD2);
  wire logic wr_frq2 = wr_stb && hit(addr, DSS_OFS_FRQ2);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd1_q <= dss_cmd_t'(DSS_RST_CMD);
      cmd2_q <= dss_cmd_t'(DSS_RST_CMD);
      frq1_q <= DSS_RST_FRQ;
      frq2_q <= DSS_RST_FRQ;
    end else begin
      if (wr_cmd1) cmd1_q <= dss_cmd_t'(wdata[1:0]);
      if (wr_frq1) frq1_q <= wdata[3:0];
      if (wr_cmd2) cmd2_q <= dss_cmd_t'(wdata[1:0]);
      if (wr_frq2) frq2_q <= wdata[3:0];
    end
  end

  // Terminal function codes, one word each
  for (genvar t = 0; t < DSS_NUM_TERM; t++) begin : g_tfn
    localparam logic [7:0] OFS = DSS_OFS_TFN0 + 8'(4 * t);
    localparam logic [4:0] RST = (t == DSS_NUM_TERM - 1) ? DSS_RST_TFN4 : DSS_RST_TFN;
    always_ff @(posedge clk) begin
      if (!resetn) begin
        tfn_q[t] <= RST;
      end else if (wr_stb && hit(addr, OFS)) begin
        tfn_q[t] <= wdata[4:0];
      end
    end
  end

  // Selector candidates; upper two terminals only on advanced parts
  logic [4:0] sel_hit;
  always_comb begin
    for (int t = 0; t < DSS_NUM_TERM; t++) begin
      sel_hit[t] = (tfn_q[t] == DSS_FN_SECOND_SRC) && term_s[t]
                   && ((t < DSS_STD_TERM) || adv_s);
    end
  end

  // One register drives both multiplexers, so they never split
  logic sel_q;
  always_ff @(posedge clk) begin
    if (!resetn) sel_q <= 1'b0;
    else         sel_q <= |sel_hit;
  end

  // Active set selection
  wire dss_cmd_t   cmd_act = sel_q ? cmd2_q : cmd1_q;
  wire logic [3:0] frq_act = sel_q ? frq2_q : frq1_q;

  // Codes that need the advanced variant
  function automatic logic frq_needs_adv(input logic [3:0] c);
    frq_needs_adv = (c == DSS_FRQ_I2I) || (c == DSS_FRQ_I2V) || (c == DSS_FRQ_POT_I)
                    || (c == DSS_FRQ_POT_V) || (c == DSS_FRQ_SERIAL);
  endfunction

  wire logic cmd_bad = ((cmd_act == DSS_CMD_SERIAL) && !adv_s);
  wire logic frq_bad = (frq_needs_adv(frq_act) && !adv_s)
                       || (frq_act > DSS_FRQ_UPDOWN);

  // Keypad run latch; run key edge sets, stop key clears
  logic key_latch_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      key_latch_q    <= 1'b0;
      key_run_prev_q <= 1'b0;
    end else begin
      key_run_prev_q <= krun_s;
      if (kstop_s)                        key_latch_q <= 1'b0;
      else if (krun_s && !key_run_prev_q) key_latch_q <= 1'b1;
    end
  end

  // Run command from the active source; terminal and serial codes follow the level at once, keypad uses the latch
  dss_run_t run_d;
  always_comb begin
    run_d = '0;
    case (cmd_act)
      DSS_CMD_KEYPAD: begin
        run_d.run = key_latch_q;
      end
      DSS_CMD_FWD_REV: begin
        run_d.run     = fwd_s ^ rev_s;
        run_d.reverse = rev_s && !fwd_s;
      end
      DSS_CMD_RUN_DIR: begin
        run_d.run     = fwd_s;
        run_d.reverse = rev_s;
      end
      DSS_CMD_SERIAL: begin
        run_d.run     = serial_run;
        run_d.reverse = serial_reverse;
      end
      default: run_d = '0;
    endcase
    if (cmd_bad) run_d = '0;
  end

  // Frequency routing decode
  dss_frq_route_t frq_d;
  always_comb begin
    frq_d = '0;
    case (frq_act)
      DSS_FRQ_KEY1:   frq_d.keypad1 = 1'b1;
      DSS_FRQ_KEY2:   frq_d.keypad2 = 1'b1;
      DSS_FRQ_POT:    frq_d.pot = 1'b1;
      DSS_FRQ_VOLT:   frq_d.volt_in = 1'b1;
      DSS_FRQ_I2I:    frq_d.cur_in = 1'b1;
      DSS_FRQ_I2V:    frq_d.shared_volt = 1'b1;
      DSS_FRQ_POT_I:  begin frq_d.pot = 1'b1; frq_d.cur_in = 1'b1; end
      DSS_FRQ_POT_V:  begin frq_d.pot = 1'b1; frq_d.shared_volt = 1'b1; end
      DSS_FRQ_POT_VOLT: begin frq_d.pot = 1'b1; frq_d.volt_in = 1'b1; end
      DSS_FRQ_SERIAL: frq_d.serial = 1'b1;
      DSS_FRQ_UPDOWN: frq_d.updown = 1'b1;
      default:        frq_d = '0;
    endcase
    if (frq_bad) frq_d = '0;
  end

  // Output registers; stop request marks a falling run
  dss_run_t       run_q;
  dss_frq_route_t frq_q;
  logic           stop_q, sec_q, bad_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_q  <= '0;
      frq_q  <= '0;
      stop_q <= 1'b0;
      sec_q  <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      run_q  <= run_d;
      frq_q  <= frq_d;
      stop_q <= run_q.run && !run_d.run;
      sec_q  <= sel_q;
      bad_q  <= cmd_bad || frq_bad;
    end
  end

  assign run_cmd       = run_q;
  assign frq_route     = frq_q;
  assign stop_request  = stop_q;
  assign second_active = sec_q;
  assign cfg_invalid   = bad_q;

  // Read path; data stand only in the cycle after the strobe
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(addr, DSS_OFS_CMD1)) rd_mux[1:0] = cmd1_q;
    if (hit(addr, DSS_OFS_FRQ1)) rd_mux[3:0] = frq1_q;
    if (hit(addr, DSS_OFS_CMD2)) rd_mux[1:0] = cmd2_q;
    if (hit(addr, DSS_OFS_FRQ2)) rd_mux[3:0] = frq2_q;
    for (int t = 0; t < DSS_NUM_TERM; t++) begin
      if (hit(addr, DSS_OFS_TFN0 + 8'(4 * t))) rd_mux[4:0] = tfn_q[t];
    end
    // Status is a snapshot of the registered outputs and of the synchronised variant strap
    if (hit(addr, DSS_OFS_STATUS)) begin
      rd_mux[15:0] = {bad_q, adv_s, sec_q, run_q, frq_q, 1'b0, stop_q, 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn)     rdata_q <= 32'h0000_0000;
    else if (rd_stb) rdata_q <= rd_mux;
    else             rdata_q <= 32'h0000_0000;
  end
  assign rdata = rdata_q;

  // Checks next to the logic
  a_sel_follows_term: assert property (@(posedge clk) disable iff (!resetn)
    (|sel_hit) |=> sel_q)
    else $error("selector did not follow terminal");
  a_first_set_used: assert property (@(posedge clk) disable iff (!resetn)
    !sel_q |-> (cmd_act == cmd1_q && frq_act == frq1_q))
    else $error("first set not used");
  a_second_set_used: assert property (@(posedge clk) disable iff (!resetn)
    sel_q |-> (cmd_act == cmd2_q && frq_act == frq2_q))
    else $error("second set not used");
  a_switch_together: assert property (@(posedge clk) disable iff (!resetn)
    $changed(sel_q) |=> $changed(sec_q) && (frq_q == $past(frq_d)) && (run_q == $past(run_d)))
    else $error("sources did not switch together");
  a_term_mode_runs: assert property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_RUN_DIR && !cmd_bad && fwd_s) |=> run_cmd.run)
    else $error("run lost while forward on");
  a_fwd_off_stops: assert property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_FWD_REV && !fwd_s && !rev_s) ##1 $past(run_q.run) |-> stop_request)
    else $error("no stop with forward off");
  a_std_no_upper: assert property (@(posedge clk) disable iff (!resetn)
    !adv_s |-> (sel_hit[4:3] == 2'b00))
    else $error("upper terminal used on standard part");
  a_adv_only_code: assert property (@(posedge clk) disable iff (!resetn)
    (!adv_s && frq_needs_adv(frq_act)) |=> (frq_route == '0) && cfg_invalid)
    else $error("advanced code accepted");
  a_combo_pot: assert property (@(posedge clk) disable iff (!resetn)
    (frq_act == DSS_FRQ_POT_VOLT) |=> (frq_route.pot && frq_route.volt_in))
    else $error("pot combination wrong");
  a_serial_stop: assert property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_SERIAL && adv_s && !serial_run) |=> !run_cmd.run)
    else $error("serial stop ignored");

  // Refusals and pulse shape
  a_sel_drops: assert property (@(posedge clk) disable iff (!resetn)
    !(|sel_hit) |=> !sel_q)
    else $error("selector stuck on");
  a_both_fwd_rev: assert property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_FWD_REV && fwd_s && rev_s) |=> !run_cmd.run)
    else $error("run with both inputs on");
  a_keypad_stop_wins: assert property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_KEYPAD && kstop_s) ##1 (cmd_act == DSS_CMD_KEYPAD) |=> !run_cmd.run)
    else $error("keypad stop ignored");
  a_stop_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
    stop_request |=> !stop_request)
    else $error("stop request longer than one cycle");
  a_code_range: assert property (@(posedge clk) disable iff (!resetn)
    (frq_act > DSS_FRQ_UPDOWN) |=> (frq_route == '0) && cfg_invalid)
    else $error("out of range code accepted");

  c_to_second: cover property (@(posedge clk) disable iff (!resetn) $rose(sec_q));
  c_back_first: cover property (@(posedge clk) disable iff (!resetn) $fell(sec_q));
  c_stop_on_switch: cover property (@(posedge clk) disable iff (!resetn)
    $changed(sel_q) ##1 stop_request);
  c_keypad_run: cover property (@(posedge clk) disable iff (!resetn)
    (cmd_act == DSS_CMD_KEYPAD) && run_cmd.run);
  c_bad_code: cover property (@(posedge clk) disable iff (!resetn)
    $rose(cfg_invalid));

endmodule // dss_select

// *** logic/dss_pkg.sv ***
package dss_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] DSS_OFS_CMD1   = 8'h00;
  localparam logic [7:0] DSS_OFS_FRQ1   = 8'h04;
  localparam logic [7:0] DSS_OFS_CMD2   = 8'h08;
  localparam logic [7:0] DSS_OFS_FRQ2   = 8'h0C;
  localparam logic [7:0] DSS_OFS_TFN0   = 8'h10;
  localparam logic [7:0] DSS_OFS_TFN4   = 8'h20;
  localparam logic [7:0] DSS_OFS_STATUS = 8'h24;

  // Values after reset
  localparam logic [1:0] DSS_RST_CMD = 2'h1;
  localparam logic [3:0] DSS_RST_FRQ = 4'h0;
  localparam logic [4:0] DSS_RST_TFN = 5'h00;
  localparam logic [4:0] DSS_RST_TFN4 = 5'h04;

  // Terminal function meaning second source
  localparam logic [4:0] DSS_FN_SECOND_SRC = 5'h16;
  localparam int         DSS_NUM_TERM      = 5;
  localparam int         DSS_STD_TERM      = 3;

  // Command source codes
  typedef enum logic [1:0] {
    DSS_CMD_KEYPAD = 2'b00,
    DSS_CMD_FWD_REV = 2'b01,
    DSS_CMD_RUN_DIR = 2'b10,
    DSS_CMD_SERIAL = 2'b11
  } dss_cmd_t;

  // Frequency source codes
  localparam logic [3:0] DSS_FRQ_KEY1   = 4'h0;
  localparam logic [3:0] DSS_FRQ_KEY2   = 4'h1;
  localparam logic [3:0] DSS_FRQ_POT    = 4'h2;
  localparam logic [3:0] DSS_FRQ_VOLT   = 4'h3;
  localparam logic [3:0] DSS_FRQ_I2I    = 4'h4;
  localparam logic [3:0] DSS_FRQ_I2V    = 4'h5;
  localparam logic [3:0] DSS_FRQ_POT_I  = 4'h6;
  localparam logic [3:0] DSS_FRQ_POT_V  = 4'h7;
  localparam logic [3:0] DSS_FRQ_POT_VOLT = 4'h8;
  localparam logic [3:0] DSS_FRQ_SERIAL = 4'h9;
  localparam logic [3:0] DSS_FRQ_UPDOWN = 4'hA;

  // Run command to the speed control
  typedef struct packed {
    logic run;
    logic reverse;
  } dss_run_t;

  // Frequency reference routing, one flag per source
  typedef struct packed {
    logic keypad1;
    logic keypad2;
    logic pot;
    logic volt_in;
    logic cur_in;
    logic shared_volt;
    logic serial;
    logic updown;
  } dss_frq_route_t;

endpackage

// *** verif/dss_far_side.sv ***
`timescale 1ns/1ps
// Far side: terminal switches, keypad keys and the serial master
module dss_far_side (
  input  wire logic       clk,
  input  wire logic [4:0] term_lvl,
  input  wire logic       fwd_lvl,
  input  wire logic       rev_lvl,
  input  wire logic       krun_lvl,
  input  wire logic       kstop_lvl,
  input  wire logic [1:0] ser_lvl,
  output logic [4:0]      term_in,
  output logic            forward_run_input,
  output logic            reverse_input,
  output logic            key_run,
  output logic            key_stop,
  output logic            serial_run,
  output logic            serial_reverse
);
  // Contacts settle well off the clock edge, so the synchroniser sees true async pins
  assign #7 term_in = term_lvl;
  assign #7 forward_run_input = fwd_lvl;
  assign #9 reverse_input = rev_lvl;
  assign #11 key_run = krun_lvl;
  assign #11 key_stop = kstop_lvl;
  // Serial logic shares the clock, so its outputs move on the edge
  always_ff @(posedge clk) begin
    {serial_run, serial_reverse} <= ser_lvl;
  end
endmodule // dss_far_side

// *** verif/dual_source_select_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module dual_source_select_tb_top;
  import dss_pkg::*;
  logic clk, resetn, wr_stb, rd_stb, advanced_io, fwd_lvl, rev_lvl, krun_lvl, kstop_lvl;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [4:0] term_lvl, term_in;
  logic [1:0] ser_lvl;
  logic fwd, rev, krun, kstop, srun, srev, stop_request, second_active, cfg_invalid;
  dss_run_t run_cmd;
  dss_frq_route_t frq_route;
  int fail_count, check_count, n;
  // Routing per frequency code 0..11, keypad1 in the top bit
  localparam logic [7:0] FRT [0:11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                                        8'h28, 8'h24, 8'h30, 8'h02, 8'h01, 8'h00};
  // Command code, forward, reverse, expected run and direction
  localparam logic [5:0] CT [0:5] = '{6'h1A, 6'h17, 6'h2F, 6'h2A, 6'h25, 6'h1C};
  localparam logic [7:0] RA [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h28};
  localparam logic [31:0] RE [0:6] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h4, 32'h0};

  dss_select dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .term_in(term_in), .forward_run_input(fwd),
    .reverse_input(rev), .key_run(krun), .key_stop(kstop), .advanced_io(advanced_io),
    .serial_run(srun), .serial_reverse(srev), .run_cmd(run_cmd), .stop_request(stop_request),
    .second_active(second_active), .frq_route(frq_route), .cfg_invalid(cfg_invalid));
  dss_far_side far (.clk(clk), .term_lvl(term_lvl), .fwd_lvl(fwd_lvl), .rev_lvl(rev_lvl),
    .krun_lvl(krun_lvl), .kstop_lvl(kstop_lvl), .ser_lvl(ser_lvl), .term_in(term_in),
    .forward_run_input(fwd), .reverse_input(rev), .key_run(krun), .key_stop(kstop),
    .serial_run(srun), .serial_reverse(srev));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pins(input logic [4:0] t, input logic f, input logic r);
    @(posedge clk);
    term_lvl <= t;
    fwd_lvl <= f;
    rev_lvl <= r;
  endtask
  task automatic stop_test;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {resetn, wr_stb, rd_stb, fwd_lvl, rev_lvl, krun_lvl, kstop_lvl} = '0;
    {addr, wdata, term_lvl, ser_lvl, fail_count, check_count} = '0;
    advanced_io = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    begin : body
    // Register values after reset, an unmapped place, then the idle status word
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], rv);
      `CHK("reg", RE[i], rv)
    end
    rd(DSS_OFS_STATUS, rv);
    `CHK("status", 32'h4400, rv)
    // Every frequency code, then one past the range
    for (int i = 0; i < 12; i++) begin
      wr(DSS_OFS_FRQ1, i);
      wt(3);
      `CHK("frq_route", FRT[i], frq_route)
      `CHK("cfg_invalid", (i > 10), cfg_invalid)
    end
    // Standard variant refuses the current input, code 4
    @(posedge clk) advanced_io <= 1'b0;
    wr(DSS_OFS_FRQ1, 32'h4);
    wt(6);
    `CHK("frq_route", 8'h00, frq_route)
    `CHK("cfg_invalid", 1'b1, cfg_invalid)
    wr(DSS_OFS_FRQ1, 32'h0);
    // Fifth terminal is no selector here, the first one is
    wr(DSS_OFS_TFN4, DSS_FN_SECOND_SRC);
    pins(5'h10, 1'b0, 1'b0);
    wt(6);
    `CHK("second_active", 1'b0, second_active)
    wr(DSS_OFS_TFN0, DSS_FN_SECOND_SRC);
    pins(5'h01, 1'b0, 1'b0);
    wt(6);
    `CHK("second_active", 1'b1, second_active)
    wr(DSS_OFS_TFN0, 32'h0);
    pins(5'h00, 1'b0, 1'b0);
    advanced_io <= 1'b1;
    // Terminal command schemes
    for (int i = 0; i < 6; i++) begin
      wr(DSS_OFS_CMD1, CT[i][5:4]);
      pins(5'h00, CT[i][3], CT[i][2]);
      wt(6);
      `CHK("run_cmd", CT[i][1:0], run_cmd)
    end
    // Keypad: run key edge starts, stop key stops
    pins(5'h00, 1'b0, 1'b0);
    wr(DSS_OFS_CMD1, DSS_CMD_KEYPAD);
    krun_lvl <= 1'b1;
    wt(5);
    @(posedge clk) krun_lvl <= 1'b0;
    wt(5);
    `CHK("run_cmd", 2'b10, run_cmd)
    @(posedge clk) kstop_lvl <= 1'b1;
    wt(5);
    `CHK("run_cmd", 2'b00, run_cmd)
    @(posedge clk) kstop_lvl <= 1'b0;
    // Second set is fully set before the selector is used
    wr(DSS_OFS_CMD1, DSS_CMD_SERIAL);
    wr(DSS_OFS_FRQ1, DSS_FRQ_SERIAL);
    wr(DSS_OFS_CMD2, DSS_CMD_FWD_REV);
    wr(DSS_OFS_FRQ2, DSS_FRQ_KEY1);
    ser_lvl <= 2'b11;
    wt(4);
    `CHK("run_cmd", 2'b11, run_cmd)
    `CHK("frq_route", 8'h02, frq_route)
    pins(5'h10, 1'b1, 1'b0);
    n = 0;
    while (second_active !== 1'b1 && n < 12) begin
      wt(1);
      n++;
    end
    `CHK("second_active", 1'b1, second_active)
    if (second_active !== 1'b1) disable body;
    `CHK("frq_route", 8'h80, frq_route)
    `CHK("run_cmd", 2'b10, run_cmd)
    // Back to a serial set that now commands stop
    @(posedge clk) ser_lvl <= 2'b00;
    pins(5'h00, 1'b1, 1'b0);
    n = 0;
    while (stop_request !== 1'b1 && n < 12) begin
      wt(1);
      n++;
    end
    `CHK("stop_request", 1'b1, stop_request)
    if (stop_request !== 1'b1) disable body;
    `CHK("run_cmd", 2'b00, run_cmd)
    @(posedge clk) ser_lvl <= 2'b10;
    wt(4);
    pins(5'h10, 1'b0, 1'b0);
    n = 0;
    while (stop_request !== 1'b1 && n < 12) begin
      wt(1);
      n++;
    end
    `CHK("stop_request", 1'b1, stop_request)
    if (stop_request !== 1'b1) disable body;
    `CHK("run_cmd", 2'b00, run_cmd)
    end
    stop_test();
  end
endmodule // dual_source_select_tb_top
